// ### rtl/rcc_ref_clock_ctrl.sv
// Purpose: Reference clock output selection and receive termination control
// Assumes: 25 MHz clk_i; pin and recovered clock inputs are asynchronous
// Notes:   Output clocks are resampled, so they carry clk_i granularity
// ==========================================================================
`timescale 1ns/1ns
`include "rcc_defs.svh"

module rcc_ref_clock_ctrl import rcc_pkg::*; #(
   parameter int NUM_CH = `RCC_NUM_CH
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic [NUM_CH-1:0]   rec_clk_i,
   input  wire logic                external_timing_input_first_i,
   input  wire logic                external_timing_input_second_i,
   input  wire logic                rx_impedance_match_pin_i,
   output logic                     ref_clock_out_first_o,
   output logic                     ref_clock_out_first_oe_o,
   output logic                     ref_clock_out_second_o,
   output logic                     ref_clock_out_second_oe_o,
   output logic                     first_input_rate_select_o,
   output logic                     second_input_rate_select_o,
   output logic [3*NUM_CH-1:0]      rx_term_o,
   output logic [NUM_CH-1:0]        rx_internal_120ohm_select_o,
   output logic [NUM_CH-1:0]        rx_hiz_o
);

   localparam int SW = NUM_CH + 3;

   typedef struct packed {
      logic [`RCC_CFG_WIDTH-1:0]               cfg_a;
      logic [`RCC_CFG_WIDTH-1:0]               cfg_b;
      logic                                    diff;
      logic [NUM_CH-1:0][`RCC_RXCFG_WIDTH-1:0] rx;
      logic                                    ack;
      logic [31:0]                             dat;
      logic                                    free;
      logic                                    out_a;
      logic                                    oe_a;
      logic                                    out_b;
      logic                                    oe_b;
      logic [3*NUM_CH-1:0]                     term;
      logic [NUM_CH-1:0]                       r120;
      logic [NUM_CH-1:0]                       hiz;
   } rcc_state_type;

   rcc_state_type     s;
   rcc_state_type     next_s;
   logic [SW-1:0]     syn;
   logic [NUM_CH-1:0] syn_rec;
   logic              syn_ext_a;
   logic              syn_ext_b;
   logic              syn_match;

   // ==========================================================================
   // Input synchronisers
   rcc_sync3 #(.WIDTH(SW)) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .async_i ({rx_impedance_match_pin_i, external_timing_input_second_i,
                 external_timing_input_first_i, rec_clk_i}),
      .sync_o  (syn)
   );

   assign syn_rec   = syn[NUM_CH-1:0];
   assign syn_ext_a = syn[NUM_CH];
   assign syn_ext_b = syn[NUM_CH+1];
   assign syn_match = syn[NUM_CH+2];

   // ==========================================================================
   // Helpers
   // Merge write data into a register by byte lanes
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // Source mux for one output; an illegal source or channel drives low
   function automatic logic pick(input logic [`RCC_CFG_WIDTH-1:0] cfg,
                                 input logic [NUM_CH-1:0] rec, input logic ext,
                                 input logic free);
      logic [4:0] ch;
      ch = cfg[`RCC_CH_MSB:0];
      pick = 1'b0;
      if (cfg[`RCC_EN_BIT]) begin
         unique case (cfg[`RCC_SRC_MSB:`RCC_SRC_LSB])
            RCC_SRC_RECOVERED: pick = (32'(ch) < NUM_CH) ? rec[ch] : 1'b0;
            RCC_SRC_EXTERNAL:  pick = ext;
            RCC_SRC_FREE_RUN:  pick = free;
            default:           pick = 1'b0;
         endcase
      end
   endfunction : pick

   // ==========================================================================
   // Next state: bus slave, output muxing and termination control
   always_comb begin
      logic        hit;
      logic        rx_hit;
      logic [7:0]  off;
      logic [5:0]  idx;
      logic [31:0] wv;
      logic        apply;
      hit    = 1'b0;
      rx_hit = 1'b0;
      off    = 8'h00;
      idx    = 6'h00;
      wv     = 32'h0000_0000;
      apply  = 1'b0;
      next_s = s;

      // Single-wait-state ack; unmapped reads return zero, writes are dropped
      hit        = wb_cyc_i && wb_stb_i && !s.ack;
      next_s.ack = hit;
      next_s.dat = 32'h0000_0000;
      off        = wb_adr_i - `RCC_OFF_RXCFG_BASE;
      idx        = off[7:2];
      rx_hit     = (wb_adr_i >= `RCC_OFF_RXCFG_BASE) && (32'(idx) < NUM_CH)
                   && (wb_adr_i[1:0] == 2'h0);
      if (hit) begin
         unique case (wb_adr_i)
            `RCC_OFF_CFG_FIRST:  next_s.dat = 32'(s.cfg_a);
            `RCC_OFF_CFG_SECOND: next_s.dat = 32'(s.cfg_b);
            `RCC_OFF_CTRL:       next_s.dat = 32'(s.diff);
            `RCC_OFF_STATUS:     next_s.dat = 32'({s.oe_b, s.oe_a, syn_match});
            default:             next_s.dat = rx_hit ? 32'(s.rx[idx]) : 32'h0000_0000;
         endcase
         if (wb_we_i) begin
            unique case (wb_adr_i)
               `RCC_OFF_CFG_FIRST: begin
                  wv = merge(32'(s.cfg_a), wb_dat_i, wb_sel_i);
                  next_s.cfg_a = wv[`RCC_CFG_WIDTH-1:0];
               end
               `RCC_OFF_CFG_SECOND: begin
                  wv = merge(32'(s.cfg_b), wb_dat_i, wb_sel_i);
                  next_s.cfg_b = wv[`RCC_CFG_WIDTH-1:0];
               end
               `RCC_OFF_CTRL: begin
                  wv = merge(32'(s.diff), wb_dat_i, wb_sel_i);
                  next_s.diff = wv[`RCC_DIFF_BIT];
               end
               default: begin
                  if (rx_hit) begin
                     wv = merge(32'(s.rx[idx]), wb_dat_i, wb_sel_i);
                     next_s.rx[idx] = wv[`RCC_RXCFG_WIDTH-1:0] & `RCC_RXCFG_MASK;
                  end
               end
            endcase
         end
      end

      // Free-running clock at half the system clock
      next_s.free = ~s.free;

      // Reference outputs; a disabled output releases its pin
      next_s.out_a = pick(s.cfg_a, syn_rec, syn_ext_a, s.free);
      next_s.oe_a  = s.cfg_a[`RCC_EN_BIT];
      next_s.out_b = pick(s.cfg_b, syn_rec, syn_ext_b, s.free);
      next_s.oe_b  = s.cfg_b[`RCC_EN_BIT];

      // Termination: pin low in differential mode floats every receiver
      apply = !s.diff || syn_match;
      for (int c = 0; c < NUM_CH; c++) begin
         next_s.hiz[c]       = s.diff && !syn_match;
         next_s.term[3*c +: 3] = apply ? s.rx[c][`RCC_TERM_MSB:0] : 3'h0;
         next_s.r120[c]      = apply ? s.rx[c][`RCC_R120_BIT] : 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s       <= '0;
         s.cfg_a <= `RCC_CFG_RESET;
         s.cfg_b <= `RCC_CFG_RESET;
         s.diff  <= `RCC_CTRL_RESET;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // ==========================================================================
   // Outputs, all straight from the state register
   assign wb_dat_o                    = s.dat;
   assign wb_ack_o                    = s.ack;
   assign ref_clock_out_first_o       = s.out_a;
   assign ref_clock_out_first_oe_o    = s.oe_a;
   assign ref_clock_out_second_o      = s.out_b;
   assign ref_clock_out_second_oe_o   = s.oe_b;
   assign first_input_rate_select_o   = s.cfg_a[`RCC_RATE_BIT];
   assign second_input_rate_select_o  = s.cfg_b[`RCC_RATE_BIT];
   assign rx_term_o                   = s.term;
   assign rx_internal_120ohm_select_o = s.r120;
   assign rx_hiz_o                    = s.hiz;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   first_off_a: assert property (ce_i && !s.cfg_a[`RCC_EN_BIT] |=>
      !ref_clock_out_first_oe_o && !ref_clock_out_first_o) else $error("first not released");
   first_on_a: assert property (ce_i && s.cfg_a[`RCC_EN_BIT] |=>
      ref_clock_out_first_oe_o) else $error("first not driven");
   second_off_a: assert property (ce_i && !s.cfg_b[`RCC_EN_BIT] |=>
      !ref_clock_out_second_oe_o && !ref_clock_out_second_o) else $error("second not released");
   second_on_a: assert property (ce_i && s.cfg_b[`RCC_EN_BIT] |=>
      ref_clock_out_second_oe_o) else $error("second not driven");
   first_free_a: assert property (ce_i && s.cfg_a[`RCC_EN_BIT]
      && s.cfg_a[`RCC_SRC_MSB:`RCC_SRC_LSB] == RCC_SRC_FREE_RUN
      |=> ref_clock_out_first_o == $past(s.free)) else $error("first free clock wrong");
   first_rec_a: assert property (ce_i && s.cfg_a[`RCC_EN_BIT]
      && s.cfg_a[`RCC_SRC_MSB:`RCC_SRC_LSB] == RCC_SRC_RECOVERED && s.cfg_a[4:0] == 5'h00
      |=> ref_clock_out_first_o == $past(syn_rec[0])) else $error("first channel wrong");
   second_ext_a: assert property (ce_i && s.cfg_b[`RCC_EN_BIT]
      && s.cfg_b[`RCC_SRC_MSB:`RCC_SRC_LSB] == RCC_SRC_EXTERNAL
      |=> ref_clock_out_second_o == $past(syn_ext_b)) else $error("second external wrong");
   rx_float_a: assert property (ce_i && s.diff && !syn_match |=>
      rx_hiz_o == '1 && rx_term_o == '0 && rx_internal_120ohm_select_o == '0)
      else $error("receivers not floated");
   rx_apply_a: assert property (ce_i && s.diff && syn_match |=>
      !rx_hiz_o[0] && rx_term_o[2:0] == $past(s.rx[0][2:0])) else $error("termination lost");
   bus_ack_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o ##1 (!wb_ack_o || !$past(ce_i))) else $error("ack timing wrong");

   first_rec_c: cover property (ref_clock_out_first_oe_o && s.cfg_a[`RCC_SRC_MSB:`RCC_SRC_LSB]
      == RCC_SRC_RECOVERED && $rose(ref_clock_out_first_o));
   second_ext_c: cover property (ref_clock_out_second_oe_o && $rose(ref_clock_out_second_o));
   rx_float_c: cover property ($rose(rx_hiz_o[0]));
   bus_write_c: cover property (wb_ack_o && wb_we_i);

endmodule : rcc_ref_clock_ctrl

// ### rtl/rcc_defs.svh
// Purpose: Offsets, field positions and reset values of the reference clock control
// Assumes: Included by its bare name; definitions only
// Notes:   Word aligned offsets on a 32-bit classic Wishbone slave
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define RCC_OFF_CFG_FIRST   8'h00
`define RCC_OFF_CFG_SECOND  8'h04
`define RCC_OFF_CTRL        8'h08
`define RCC_OFF_STATUS      8'h0C
`define RCC_OFF_RXCFG_BASE  8'h10

// ==========================================================================
// Output configuration fields
`define RCC_CH_MSB          4
`define RCC_RATE_BIT        5
`define RCC_EN_BIT          6
`define RCC_SRC_LSB         7
`define RCC_SRC_MSB         8
`define RCC_CFG_WIDTH       9
`define RCC_CFG_RESET       9'h000

// ==========================================================================
// Receive configuration fields (per channel)
`define RCC_TERM_MSB        2
`define RCC_R120_BIT        4
`define RCC_RXCFG_WIDTH     5
`define RCC_RXCFG_MASK      5'h17
`define RCC_RXCFG_RESET     5'h00

// ==========================================================================
// Global control and misc
`define RCC_DIFF_BIT        0
`define RCC_CTRL_RESET      1'h1
`define RCC_NUM_CH          17

`endif

// ### rtl/rcc_pkg.sv
// Purpose: Shared types of the reference clock control
// Assumes: Nothing
// Notes:   Constants live in rcc_defs.svh
package rcc_pkg;

   // Source selected for a reference clock output
   typedef enum logic [1:0] {
      RCC_SRC_RECOVERED,
      RCC_SRC_EXTERNAL,
      RCC_SRC_FREE_RUN
   } rcc_src_type;

endpackage : rcc_pkg

// ### rtl/rcc_sync3.sv
// Purpose: Three-flop input synchroniser with agreement filter
// Assumes: Inputs come from outside the clk_i domain
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ns

module rcc_sync3 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } rcc_sync_type;

   rcc_sync_type s;
   rcc_sync_type next_s;

   // First stage feeds only the second, so metastability stays contained
   always_comb begin
      next_s    = s;
      next_s.s1 = async_i;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (s.s2[i] == s.s3[i]) begin
            next_s.q[i] = s.s3[i];
         end
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign sync_o = s.q;

endmodule : rcc_sync3

// ### bench/rcc_partner.sv
// Purpose: Far-side timing model: source clocks out, reference clocks in
// Assumes: External clock half periods in ns are handed down by the bench; recovered ones are fixed here
// Notes:   Edges are counted only while a pin is driven; a floating pin counts nothing
`timescale 1ns/1ns

module rcc_partner #(
   parameter int HP_EXT1 = 324,
   parameter int HP_EXT2 = 244
) (
   input  wire logic        clear_i,
   input  wire logic        ref_first_i,
   input  wire logic        ref_first_oe_i,
   input  wire logic        ref_second_i,
   input  wire logic        ref_second_oe_i,
   output logic [16:0]      rec_clk_o,
   output logic             ext_first_o,
   output logic             ext_second_o,
   output int               rise_first_o,
   output int               rise_second_o
);
   // ==========================================================================
   // Source clocks: each channel has its own rate, so a misroute shows in counts
   for (genvar c = 0; c < 17; c++) begin : g_rec
      initial begin
         rec_clk_o[c] = 1'b0;
         forever #(200 + 40 * c) rec_clk_o[c] = ~rec_clk_o[c];
      end
   end
   initial begin
      ext_first_o = 1'b0;
      forever #(HP_EXT1) ext_first_o = ~ext_first_o;
   end
   initial begin
      ext_second_o = 1'b0;
      forever #(HP_EXT2) ext_second_o = ~ext_second_o;
   end

   // ==========================================================================
   // Consumers: a released pin is high impedance, so nothing is counted then
   always @(posedge ref_first_i or posedge clear_i) begin
      if (clear_i) rise_first_o = 0;
      else if (ref_first_oe_i === 1'b1) rise_first_o++;
   end
   always @(posedge ref_second_i or posedge clear_i) begin
      if (clear_i) rise_second_o = 0;
      else if (ref_second_oe_i === 1'b1) rise_second_o++;
   end
endmodule : rcc_partner

// ### bench/tb_top.sv
// Purpose: Self-checking bench of the reference clock control
// Assumes: ce_i held high; bus answers within a few cycles
// Notes:   Clock routing is judged by edge counts over a fixed window, +-1
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module tb_top import rcc_pkg::*;;
   localparam int HP1 = 324;
   localparam int HP2 = 244;
   localparam int WIN = 200;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pin = 0, clr = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, dat_o, q;
   logic        ack, o1, oe1, o2, oe2, rate1, rate2, e1, e2;
   logic [50:0] term;
   logic [16:0] rec, r120, hiz;
   int          rise1, rise2, cyc_cnt = 0, mismatches = 0, checks = 0;

   // ==========================================================================
   // Clock, design and far side
   initial forever #20 clk_i = ~clk_i;
   rcc_ref_clock_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .rec_clk_i(rec), .external_timing_input_first_i(e1),
      .external_timing_input_second_i(e2), .rx_impedance_match_pin_i(pin),
      .ref_clock_out_first_o(o1), .ref_clock_out_first_oe_o(oe1),
      .ref_clock_out_second_o(o2), .ref_clock_out_second_oe_o(oe2),
      .first_input_rate_select_o(rate1), .second_input_rate_select_o(rate2),
      .rx_term_o(term), .rx_internal_120ohm_select_o(r120), .rx_hiz_o(hiz));
   rcc_partner #(.HP_EXT1(HP1), .HP_EXT2(HP2)) far (.clear_i(clr), .ref_first_i(o1),
      .ref_first_oe_i(oe1), .ref_second_i(o2), .ref_second_oe_i(oe2), .rec_clk_o(rec),
      .ext_first_o(e1), .ext_second_o(e2), .rise_first_o(rise1), .rise_second_o(rise2));

   // ==========================================================================
   // Bus cycle: request held until ack is sampled, then released for a cycle
   // Only the global cycle ceiling ends a wait; the slave should answer at the second edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      `CHK(n, 2)
   endtask : wb

   // Routes one output, then counts its rising edges over the window
   task automatic route(input bit sec, input logic [8:0] cfg, input int hp);
      int exp, got;
      exp = (cfg[6] && hp > 0) ? (WIN * 40) / (2 * hp) : 0;
      wb(1'b1, sec ? 8'h04 : 8'h00, {23'h0, cfg});
      repeat (8) @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (WIN) @(posedge clk_i);
      got = sec ? rise2 : rise1;
      `CHK(got >= exp - 1 && got <= exp + 1, 1'b1)
      `CHK(sec ? oe2 : oe1, cfg[6])
      `CHK(sec ? rate2 : rate1, cfg[5])
      if (!cfg[6]) `CHK(sec ? o2 : o1, 1'b0)
   endtask : route

   task automatic test_reset();
      wb(1'b0, 8'h00, 32'h0);
      `CHK(q, 32'h0)
      wb(1'b0, 8'h08, 32'h0);
      `CHK(q, 32'h1)
      wb(1'b0, 8'hFC, 32'h0);
      `CHK(q, 32'h0)
      `CHK({oe1, oe2}, 2'h0)
      $display("test reset done");
   endtask : test_reset

   task automatic test_routes();
      for (int s = 0; s < 2; s++) begin
         route(s[0], {RCC_SRC_RECOVERED, 2'b10, 5'd0}, 200);
         route(s[0], {RCC_SRC_RECOVERED, 2'b10, 5'd16}, 840);
         route(s[0], {RCC_SRC_RECOVERED, 2'b10, 5'd17}, 0);
         route(s[0], {RCC_SRC_EXTERNAL, 2'b11, 5'd0}, s ? HP2 : HP1);
         // Free clock toggles once per clock cycle, so its half period is 40 ns
         route(s[0], {RCC_SRC_FREE_RUN, 2'b10, 5'd0}, 40);
         route(s[0], {RCC_SRC_FREE_RUN, 2'b01, 5'd0}, 40);
         route(s[0], {2'b11, 2'b10, 5'd0}, 0);
      end
      $display("test routes done");
   endtask : test_routes

   task automatic test_match();
      wb(1'b1, 8'h10, 32'h1F);
      wb(1'b1, 8'h50, 32'h05);
      wb(1'b0, 8'h10, 32'h0);
      `CHK(q, 32'h17)
      pin <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK(hiz, 17'h1FFFF)
      `CHK({term, r120}, 68'h0)
      pin <= 1'b1;
      repeat (8) @(posedge clk_i);
      `CHK(hiz, 17'h0)
      `CHK({term[50:48], term[2:0], r120[16], r120[0]}, 8'hBD)
      wb(1'b0, 8'h0C, 32'h0);
      `CHK(q, 32'h7)
      // Single-ended mode never floats, so the settings apply even with the pin low
      wb(1'b1, 8'h08, 32'h0);
      pin <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK(hiz, 17'h0)
      `CHK({term[2:0], r120[0]}, 4'hF)
      $display("test match done");
   endtask : test_match

   // ==========================================================================
   // Verdict and hang guard
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test

   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      test_reset();
      test_routes();
      test_match();
      finish_test();
   end
endmodule : tb_top
